// ---- src/lhc_regs.sv ----
// link host control and self-id pointer registers on an AHB-Lite slave

// How it works
// - reserved control bits 31, 29-24, 21-20, 15-0 always read zero
// - bit 30 selects byte swapping of outside and DMA data accesses
// - bit 23 grants enhancement ownership, cleared by software, eeprom loads it
// - link power bit zero blocks all link to phy communication
// - bit 18 enables posted writes when one, disables when zero
// - bus connect bit 17 cleared by hardware reset and soft reset
// - bus connect zero: no packet received, processed or sent, at once
// - writing bit 16 resets link state, flushes fifos, resets registers
// - bit 16 reads one during soft reset, clears itself when done
// - pointer register holds 2-Kbyte aligned self-id buffer base
// - only pointer bits 31-11 writable, bits 10-0 read zero
// - flags reached via set address 50h and clear address 54h
module lhc_regs #(
  parameter logic [7:0] SRST_CYCLES = lhc_pkg::SRST_CYCLES
) (
  input  wire logic                    REF_CLK,
  input  wire logic                    NRST,
  input  wire logic                    HSEL,
  input  wire logic [31:0]             HADDR,
  input  wire logic [1:0]              HTRANS,
  input  wire logic                    HWRITE,
  input  wire logic [2:0]              HSIZE,
  input  wire logic [31:0]             HWDATA,
  input  wire logic                    HREADY,
  output logic      [31:0]             HRDATA,
  output logic                         HREADYOUT,
  output logic                         HRESP,
  input  wire logic                    EEPROM_LOAD,
  input  wire logic                    EEPROM_OWNER,
  output lhc_pkg::lhc_link_ctrl_t      LINK_CTRL
);

  lhc_pkg::lhc_state_t s;
  lhc_pkg::lhc_state_t next_s;
  logic [31:0]         ctrl_word;
  logic [31:0]         rd_word;
  logic                take;
  logic                wr_ok;

  // control word as read back: stored flags plus soft reset in progress
  always_comb
  begin
    ctrl_word = s.ctrl & lhc_pkg::CTRL_RD_MASK;
    ctrl_word[lhc_pkg::BIT_SRST] = s.busy;
  end

  // read decode; unmapped addresses read zero
  always_comb
  begin
    case (s.addr)
      lhc_pkg::OFS_CTRL_SET: rd_word = ctrl_word;
      lhc_pkg::OFS_CTRL_CLR: rd_word = ctrl_word;
      lhc_pkg::OFS_SID_BASE: rd_word = {s.sid, 11'h000};
      default:               rd_word = 32'h0000_0000;
    endcase
  end

  // address phase accepted; hsize is not checked, whole words assumed
  assign take  = HSEL && HTRANS[1] && HREADY;
  // register writes are dropped while a soft reset runs
  assign wr_ok = (s.ph == lhc_pkg::PH_WRITE) && !s.busy;

  // next state: bus phases, register writes, soft reset, eeprom load
  always_comb
  begin
    next_s = s;
    case (s.ph)
      lhc_pkg::PH_IDLE:
      begin
        next_s.ph = lhc_pkg::PH_IDLE;
      end
      lhc_pkg::PH_WRITE:
      begin
        next_s.ph = lhc_pkg::PH_IDLE;
      end
      lhc_pkg::PH_READ_WAIT:
      begin
        next_s.rdata = rd_word;
        next_s.ph    = lhc_pkg::PH_READ_DONE;
      end
      lhc_pkg::PH_READ_DONE:
      begin
        next_s.ph = lhc_pkg::PH_IDLE;
      end
      default:
      begin
        next_s.ph = lhc_pkg::PH_IDLE;
      end
    endcase
    // soft reset countdown, bit drops by itself at the end
    if (s.busy)
    begin
      next_s.cnt = s.cnt - 8'h01;
      if (s.cnt == 8'h01)
      begin
        next_s.busy = 1'b0;
      end
    end
    // register writes in the data phase
    if (wr_ok)
    begin
      case (s.addr)
        lhc_pkg::OFS_CTRL_SET:
        begin
          next_s.ctrl = s.ctrl | (HWDATA & lhc_pkg::CTRL_SET_MASK);
          if (HWDATA[lhc_pkg::BIT_SRST])
          begin
            // flags and pointer back to reset values, owner bit kept
            next_s.ctrl = s.ctrl & (32'h0000_0001 << lhc_pkg::BIT_OWNER);
            next_s.ctrl[lhc_pkg::BIT_CONNECT] = 1'b0;
            next_s.sid  = lhc_pkg::SID_RESET;
            next_s.busy = 1'b1;
            next_s.cnt  = SRST_CYCLES;
          end
        end
        lhc_pkg::OFS_CTRL_CLR:
        begin
          next_s.ctrl = s.ctrl & ~(HWDATA & lhc_pkg::CTRL_CLR_MASK);
        end
        lhc_pkg::OFS_SID_BASE:
        begin
          next_s.sid = HWDATA[31:lhc_pkg::SID_LSB];
        end
        default:
        begin
          next_s.sid = s.sid;
        end
      endcase
    end
    // eeprom load of the ownership flag beats a same-cycle clear
    if (EEPROM_LOAD)
    begin
      next_s.ctrl[lhc_pkg::BIT_OWNER] = EEPROM_OWNER;
    end
    // a new address phase
    if (take)
    begin
      next_s.addr = HADDR[7:0];
      next_s.ph   = HWRITE ? lhc_pkg::PH_WRITE : lhc_pkg::PH_READ_WAIT;
    end
  end

  // state register
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s.ph    <= lhc_pkg::PH_IDLE;
      s.addr  <= 8'h00;
      s.ctrl  <= lhc_pkg::CTRL_RESET;
      s.sid   <= lhc_pkg::SID_RESET;
      s.busy  <= 1'b0;
      s.cnt   <= 8'h00;
      s.rdata <= 32'h0000_0000;
    end
    else
    begin
      s <= next_s;
    end
  end

  // bus answers: one wait state on reads so prior writes are visible
  assign HREADYOUT = (s.ph != lhc_pkg::PH_READ_WAIT);
  assign HRESP     = 1'b0;
  assign HRDATA    = s.rdata;

  // link control levels
  always_comb
  begin
    LINK_CTRL.swap_disable = s.ctrl[lhc_pkg::BIT_SWAP_DIS];
    LINK_CTRL.config_owner = s.ctrl[lhc_pkg::BIT_OWNER];
    LINK_CTRL.enh_use      = s.ctrl[lhc_pkg::BIT_ENH_USE];
    LINK_CTRL.phy_comm     = s.ctrl[lhc_pkg::BIT_PWR_ON] && !s.busy;
    LINK_CTRL.post_en      = s.ctrl[lhc_pkg::BIT_POST_EN];
    LINK_CTRL.connect      = s.ctrl[lhc_pkg::BIT_CONNECT];
    LINK_CTRL.pkt_allow    = s.ctrl[lhc_pkg::BIT_CONNECT] && !s.busy;
    LINK_CTRL.link_flush   = s.busy;
    LINK_CTRL.sid_base     = {s.sid, 11'h000};
  end

  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  // helper: length of the current soft reset
  logic [7:0] busy_len;
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      busy_len <= 8'h00;
    end
    else
    begin
      busy_len <= s.busy ? busy_len + 8'h01 : 8'h00;
    end
  end

  a_ctrl_reserved_zero: assert property (
    (ctrl_word & ~lhc_pkg::CTRL_RD_MASK) == 32'h0000_0000)
    else $error("reserved control bit reads nonzero");

  a_sid_low_zero: assert property (
    (s.ph == lhc_pkg::PH_READ_WAIT) && (s.addr == lhc_pkg::OFS_SID_BASE)
    |=> HREADYOUT && (HRDATA[10:0] == 11'h000))
    else $error("pointer low bits read nonzero");

  a_srst_length: assert property (
    $fell(s.busy) |-> (busy_len == SRST_CYCLES))
    else $error("soft reset length wrong");

  a_srst_disconnects: assert property (
    $rose(s.busy) |-> !LINK_CTRL.connect && !LINK_CTRL.pkt_allow)
    else $error("soft reset left bus connected");

  a_no_packets_off: assert property (
    !s.ctrl[lhc_pkg::BIT_CONNECT] |-> !LINK_CTRL.pkt_allow)
    else $error("packets allowed while disconnected");

  a_phy_blocked: assert property (
    !s.ctrl[lhc_pkg::BIT_PWR_ON] |-> !LINK_CTRL.phy_comm)
    else $error("phy traffic allowed with power bit low");

  a_set_post_en: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_SET) && HWDATA[18] && !HWDATA[16]
    |=> LINK_CTRL.post_en)
    else $error("set write did not enable posting");

  a_clr_connect: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_CLR) && HWDATA[17]
    |=> !LINK_CTRL.connect ##1 !LINK_CTRL.pkt_allow)
    else $error("clear write did not drop bus connect");

  a_owner_load: assert property (
    EEPROM_LOAD && EEPROM_OWNER |=> LINK_CTRL.config_owner)
    else $error("eeprom load of owner flag lost");

  a_read_wait: assert property (
    take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");

  // bus answer checks
  a_write_no_wait: assert property (
    (s.ph == lhc_pkg::PH_WRITE) |-> HREADYOUT)
    else $error("write data phase stalled");

  a_resp_okay: assert property (
    HRESP == 1'b0)
    else $error("bus response not okay");

  a_rd_unmapped: assert property (
    (s.ph == lhc_pkg::PH_READ_WAIT) && (s.addr != lhc_pkg::OFS_CTRL_SET) &&
    (s.addr != lhc_pkg::OFS_CTRL_CLR) && (s.addr != lhc_pkg::OFS_SID_BASE)
    |=> (HRDATA == 32'h0000_0000))
    else $error("unmapped read nonzero");

  // flag set and clear checks
  a_set_swap: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_SET) && HWDATA[30] && !HWDATA[16]
    |=> LINK_CTRL.swap_disable)
    else $error("set write did not set swap bit");

  a_clr_swap: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_CLR) && HWDATA[30]
    |=> !LINK_CTRL.swap_disable)
    else $error("clear write did not drop swap bit");

  a_set_power: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_SET) && HWDATA[19] && !HWDATA[16]
    |=> ctrl_word[lhc_pkg::BIT_PWR_ON])
    else $error("set write did not raise power bit");

  a_clr_post: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_CLR) && HWDATA[18]
    |=> !LINK_CTRL.post_en)
    else $error("clear write did not disable posting");

  a_set_enh: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_SET) && HWDATA[22] && !HWDATA[16]
    |=> LINK_CTRL.enh_use)
    else $error("set write did not set enhancement bit");

  a_clr_enh: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_CLR) && HWDATA[22]
    |=> !LINK_CTRL.enh_use)
    else $error("clear write did not drop enhancement bit");

  a_zero_keeps: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_SET) && !HWDATA[16] &&
    s.ctrl[lhc_pkg::BIT_CONNECT] |=> LINK_CTRL.connect)
    else $error("set write with zero bit lost a flag");

  a_clr_owner: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_CTRL_CLR) && HWDATA[23] && !EEPROM_LOAD
    |=> !LINK_CTRL.config_owner)
    else $error("clear write did not drop owner flag");

  a_owner_no_set: assert property (
    !s.ctrl[lhc_pkg::BIT_OWNER] && !EEPROM_LOAD |=> !LINK_CTRL.config_owner)
    else $error("owner flag set by software");

  // soft reset checks
  a_srst_flush: assert property (
    s.busy |-> LINK_CTRL.link_flush && !LINK_CTRL.phy_comm)
    else $error("soft reset did not flush");

  a_srst_reads_one: assert property (
    s.busy |-> ctrl_word[lhc_pkg::BIT_SRST])
    else $error("soft reset bit reads zero while busy");

  a_srst_no_packets: assert property (
    s.busy |-> !LINK_CTRL.pkt_allow)
    else $error("packets allowed during soft reset");

  a_srst_clears: assert property (
    $rose(s.busy) |-> !LINK_CTRL.post_en && !LINK_CTRL.swap_disable &&
    (LINK_CTRL.sid_base == 32'h0000_0000))
    else $error("soft reset left registers set");

  a_srst_ignores: assert property (
    s.busy && (s.ph == lhc_pkg::PH_WRITE) |=> $stable(LINK_CTRL.sid_base))
    else $error("write landed during soft reset");

  // pointer checks
  a_sid_write: assert property (
    wr_ok && (s.addr == lhc_pkg::OFS_SID_BASE)
    |=> LINK_CTRL.sid_base[31:11] == $past(HWDATA[31:11]))
    else $error("pointer write lost");

  a_sid_aligned: assert property (
    LINK_CTRL.sid_base[10:0] == 11'h000)
    else $error("pointer base not aligned");

endmodule // lhc_regs

// ---- shared/lhc_pkg.sv ----
// constants and types for the link host control register bank
package lhc_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL_SET = 8'h50;
  localparam logic [7:0]  OFS_CTRL_CLR = 8'h54;
  localparam logic [7:0]  OFS_SID_BASE = 8'h64;
  // control word bit positions
  localparam int          BIT_SWAP_DIS = 30;
  localparam int          BIT_OWNER    = 23;
  localparam int          BIT_ENH_USE  = 22;
  localparam int          BIT_PWR_ON   = 19;
  localparam int          BIT_POST_EN  = 18;
  localparam int          BIT_CONNECT  = 17;
  localparam int          BIT_SRST     = 16;
  // implemented bits, bits software may set, bits software may clear
  localparam logic [31:0] CTRL_RD_MASK  = 32'h40CF_0000;
  localparam logic [31:0] CTRL_SET_MASK = 32'h404E_0000;
  localparam logic [31:0] CTRL_CLR_MASK = 32'h40CE_0000;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  // self-id base pointer: writable field starts at this bit
  localparam int          SID_LSB      = 11;
  localparam logic [20:0] SID_RESET    = 21'h00_0000;
  // soft reset duration in clock cycles
  localparam logic [7:0]  SRST_CYCLES  = 8'h10;

  // bus data phase states
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ_WAIT,
    PH_READ_DONE
  } lhc_phase_t;

  // control levels handed to the link logic
  typedef struct packed {
    logic        swap_disable;
    logic        config_owner;
    logic        enh_use;
    logic        phy_comm;
    logic        post_en;
    logic        connect;
    logic        pkt_allow;
    logic        link_flush;
    logic [31:0] sid_base;
  } lhc_link_ctrl_t;

  // whole state of the register bank
  typedef struct packed {
    lhc_phase_t  ph;
    logic [7:0]  addr;
    logic [31:0] ctrl;
    logic [20:0] sid;
    logic        busy;
    logic [7:0]  cnt;
    logic [31:0] rdata;
  } lhc_state_t;
endpackage

// ---- dv/tb_lhc_regs.sv ----
// self-checking bench for the link host control register bank
module tb_lhc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    REF_CLK, NRST, HSEL, HWRITE, HREADY;
  logic                    HREADYOUT, HRESP, EEPROM_LOAD, EEPROM_OWNER;
  logic [31:0]             HADDR, HWDATA, HRDATA;
  logic [1:0]              HTRANS;
  logic [2:0]              HSIZE;
  lhc_pkg::lhc_link_ctrl_t LINK_CTRL;
  logic [31:0]             q[$];
  logic [31:0]             fl, pt, r;
  logic                    rd_ph, sr;
  int                      miscompares, n_checks, cyc, seed;

  // device under test with a short soft reset
  lhc_regs #(.SRST_CYCLES(8'h08)) i_lhc_regs (
    .REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .EEPROM_LOAD(EEPROM_LOAD),
    .EEPROM_OWNER(EEPROM_OWNER), .LINK_CTRL(LINK_CTRL));

  // single slave, so its ready is the bus ready
  assign HREADY = HREADYOUT;

  // 50 MHz clock
  initial
  begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  // compares one result and counts it
  task automatic cmp(input logic [39:0] e, input logic [39:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // prints counts and verdict, then stops
  task automatic conclude;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one single AHB-Lite word transfer
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h00_0000, a};
    HWRITE <= w;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_ph <= ~w;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  // read with its expected word noted in the queue
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  // link control levels worked out from the tracked flags
  task automatic chk_link;
    lhc_pkg::lhc_link_ctrl_t e;
    e = '{fl[30], fl[23], fl[22], fl[19] & !sr, fl[18], fl[17],
          fl[17] & !sr, sr, {pt[31:11], 11'h000}};
    @(negedge REF_CLK);
    cmp(e, LINK_CTRL);
    @(posedge REF_CLK);
  endtask

  // read data watcher: oldest note against each finished read
  always @(posedge REF_CLK)
    if (rd_ph && HREADYOUT === 1'b1)
      cmp({8'h00, q.pop_front()}, {7'h00, HRESP, HRDATA});

  // cuts a hang short
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      conclude;
    end
  end

  // main sequence
  initial
  begin
    NRST = 1'b0; HSEL = 1'b0; HTRANS = 2'h0; HADDR = 32'h0;
    HWRITE = 1'b0; HSIZE = 3'h2; HWDATA = 32'h0; EEPROM_LOAD = 1'b0;
    EEPROM_OWNER = 1'b0; rd_ph = 1'b0; sr = 1'b0; fl = 32'h0; pt = 32'h0;
    miscompares = 0; n_checks = 0; seed = 52718;
    repeat (8) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    rd(8'h50, 32'h0);
    rd(8'h54, 32'h0);
    rd(8'h64, 32'h0);
    chk_link;
    $display("test 1 done: reset values");
    xfer(1'b1, 8'h50, 32'hFFBE_FFFF);
    fl = 32'h400E_0000;
    rd(8'h50, fl);
    rd(8'h54, fl);
    chk_link;
    EEPROM_OWNER <= 1'b1;
    EEPROM_LOAD <= 1'b1;
    @(posedge REF_CLK);
    EEPROM_LOAD <= 1'b0;
    fl[23] = 1'b1;
    rd(8'h50, fl);
    chk_link;
    $display("test 2 done: set and eeprom owner");
    repeat (6)
    begin
      r = $random(seed);
      if (fl[17]) r[18] = 1'b0;
      if (!fl[23]) r[22] = 1'b0;
      xfer(1'b1, 8'h54, r);
      fl &= ~(r & lhc_pkg::CTRL_CLR_MASK);
      rd(8'h54, fl);
      chk_link;
      r = $random(seed) & 32'hFFFE_FFFF;
      if (!(fl[23] && fl[17])) r[22] = 1'b0;
      if (fl[17]) r[18] = 1'b0;
      xfer(1'b1, 8'h50, r);
      fl |= r & lhc_pkg::CTRL_SET_MASK;
      rd(8'h50, fl);
      chk_link;
    end
    $display("test 3 done: random set and clear");
    repeat (4)
    begin
      r = $random(seed);
      xfer(1'b1, 8'h64, r);
      pt = r & 32'hFFFF_F800;
      rd(8'h64, pt);
      chk_link;
    end
    xfer(1'b1, 8'h60, r);
    rd(8'h60, 32'h0);
    rd(8'h64, pt);
    $display("test 4 done: pointer and unmapped");
    xfer(1'b1, 8'h50, 32'h0002_0000);
    xfer(1'b1, 8'h50, 32'h0001_0000);
    fl = (fl & 32'h0080_0000) | 32'h0001_0000;
    pt = 32'h0;
    sr = 1'b1;
    rd(8'h50, fl);
    chk_link;
    xfer(1'b1, 8'h50, 32'h0008_0000);
    repeat (10) @(posedge REF_CLK);
    sr = 1'b0;
    fl[16] = 1'b0;
    rd(8'h50, fl);
    rd(8'h64, 32'h0);
    chk_link;
    $display("test 5 done: soft reset");
    conclude;
  end
endmodule // tb_lhc_regs
